// >>> core/nvs_pkg.sv
package nvs_pkg;
   localparam int CLK_PERIOD_NS   = 10;
   // access phase lengths in ns, rounded up to whole cycles
   localparam int ACCESS_NS       = 45;   // slowest grade cycle time
   localparam int ACCESS_CYC      = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HW_SAVE_NS      = 15;   // least pulse on store_busy_line_n
   localparam int HW_SAVE_CYC     = (HW_SAVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int GRACE_NS        = 25;   // write_grace_window, slowest grade
   localparam int GRACE_CYC       = (GRACE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SOFT_SEQ_LEN    = 6;
   localparam int SEQ_W           = 3;
   localparam int CNT_W           = 8;
   // operation codes on the command port
   localparam logic [1:0] OP_READ     = 2'h0;
   localparam logic [1:0] OP_WRITE    = 2'h1;
   localparam logic [1:0] OP_HW_SAVE  = 2'h2;
   localparam logic [1:0] OP_SOFT_CMD = 2'h3;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_SETUP = 5'h02,
      ST_PULSE = 5'h04,
      ST_GAP   = 5'h08,
      ST_BUSY  = 5'h10
   } nvs_state_type;

   typedef struct packed {
      logic [1:0]  op;
      logic [19:0] addr;
      logic [15:0] wdata;
      logic [1:0]  lanes_n;   // [1] upper, [0] lower
   } nvs_req_type;

   typedef struct packed {
      logic        ce_n;
      logic        we_n;
      logic        oe_n;
      logic        ub_n;
      logic        lb_n;
      logic [19:0] addr;
      logic [15:0] dq;
      logic [15:0] dq_oe;
      logic        busy_out;
      logic        busy_oe;
   } nvs_pins_type;
endpackage

// >>> core/nvs_host.sv
module nvs_host #(
   parameter int          DATA_W    = 16,
   parameter int          ADDR_W    = 20,
   parameter logic [19:0] SEQ_ADDR0 = 20'h00000,
   parameter logic [19:0] SEQ_ADDR1 = 20'h00001,
   parameter logic [19:0] SEQ_ADDR2 = 20'h00002,
   parameter logic [19:0] SEQ_ADDR3 = 20'h00003,
   parameter logic [19:0] SEQ_ADDR4 = 20'h00004,
   parameter logic [19:0] SEQ_ADDR5 = 20'h00005
) (
   input  wire logic                MCLK_I,
   input  wire logic                RESET_I,
   input  wire logic                REQ_VALID_I,
   input  wire nvs_pkg::nvs_req_type REQ_I,
   output logic                     REQ_READY_O,
   output logic                     RDATA_VALID_O,
   output logic [15:0]              RDATA_O,
   output logic                     NV_BUSY_O,
   output logic                     CE_N_O,
   output logic                     WE_N_O,
   output logic                     OE_N_O,
   output logic                     UB_N_O,
   output logic                     LB_N_O,
   output logic [19:0]              ADDR_O,
   output logic [15:0]              DQ_O,
   output logic [15:0]              DQ_OE_O,
   input  wire logic [15:0]         DQ_I,
   output logic                     BUSY_LINE_N_O,
   output logic                     BUSY_LINE_N_OE_O,
   input  wire logic                BUSY_LINE_N_I
);
   // all state in one struct, copied whole on every edge
   //   st       - one-hot phase of the access engine
   //   req      - request latched at take, held to completion
   //   pin      - registered pad values, so no output glitches
   //   cnt      - cycle count inside the current phase
   //   seq      - step of the six-read command sequence
   //   bsy_sync - two-flop synchroniser for the busy line
   //   dq_sync  - two-flop synchroniser for the data bus
   //   rvalid   - one-cycle read data strobe
   //   rdata    - last read word, held until the next read
   //   ready    - request port open
   typedef struct packed {
      nvs_pkg::nvs_state_type st;
      nvs_pkg::nvs_req_type   req;
      nvs_pkg::nvs_pins_type  pin;
      logic [7:0]             cnt;
      logic [2:0]             seq;
      logic [1:0]             bsy_sync;
      logic [31:0]            dq_sync;
      logic                   rvalid;
      logic [15:0]            rdata;
      logic                   ready;
   } nvs_regs_type;

   nvs_regs_type r_q;
   nvs_regs_type r_d;
   logic [19:0]  seq_addr;
   logic         wide;

   // 8-bit parts ignore the byte selects, so they are parked
   assign wide = (DATA_W == 16);

   // address of the current soft command step; the table is a
   // parameter set because the command addresses differ per
   // part, and a wrong table only makes the device ignore it
   always_comb begin
      case (r_q.seq)
         3'h0:    seq_addr = SEQ_ADDR0;
         3'h1:    seq_addr = SEQ_ADDR1;
         3'h2:    seq_addr = SEQ_ADDR2;
         3'h3:    seq_addr = SEQ_ADDR3;
         3'h4:    seq_addr = SEQ_ADDR4;
         default: seq_addr = SEQ_ADDR5;
      endcase
   end

   // phase walk of one access, one line per phase:
   //   idle  - take the request, strobes parked high
   //   setup - select, strobes and address launched together
   //   pulse - strobes held for the slowest grade cycle time
   //   gap   - select high for the grace window between steps
   //   busy  - wait until the device lets go of the busy line
   // read data is sampled two cycles late through the flops,
   // so the pulse is long enough to cover the flop latency
   // trade-off: one fixed timing for every grade costs speed
   // on fast parts but needs no grade strap
   // every request ends in busy; command steps before the sixth go back to setup
   // one access engine; every pin comes from the state struct
   always_comb begin
      r_d          = r_q;
      r_d.rvalid   = 1'b0;
      r_d.bsy_sync = {r_q.bsy_sync[0], BUSY_LINE_N_I};
      r_d.dq_sync  = {r_q.dq_sync[15:0], DQ_I};
      case (r_q.st)
         nvs_pkg::ST_IDLE: begin
            r_d.pin.ce_n     = 1'b1;
            r_d.pin.we_n     = 1'b1;
            r_d.pin.oe_n     = 1'b1;
            r_d.pin.dq_oe    = 16'h0000;
            r_d.pin.busy_oe  = 1'b0;
            r_d.pin.busy_out = 1'b1;
            // a device still busy (low) holds off new work
            // ready follows the synchronised line one cycle late,
            // and the take checks the line again, so a stale
            // busy sample never lets a request through
            r_d.ready        = r_q.bsy_sync[1];
            if (REQ_VALID_I && r_q.ready && r_q.bsy_sync[1]) begin
               r_d.ready = 1'b0;
               r_d.req   = REQ_I;
               r_d.seq   = 3'h0;
               r_d.cnt   = 8'h00;
               r_d.st    = nvs_pkg::ST_SETUP;
            end
         end
         nvs_pkg::ST_SETUP: begin
            // address, lanes and strobes leave the same flops together;
            // zero address setup is allowed, so no extra phase is spent
            r_d.pin.addr = (r_q.req.op == nvs_pkg::OP_SOFT_CMD) ? seq_addr : r_q.req.addr;
            r_d.pin.ub_n = wide ? r_q.req.lanes_n[1] : 1'b1;
            r_d.pin.lb_n = wide ? r_q.req.lanes_n[0] : 1'b0;
            r_d.cnt      = 8'h00;
            r_d.st       = nvs_pkg::ST_PULSE;
            if (r_q.req.op == nvs_pkg::OP_HW_SAVE) begin
               r_d.pin.busy_oe  = 1'b1;
               r_d.pin.busy_out = 1'b0;
            end else if (r_q.req.op == nvs_pkg::OP_WRITE) begin
               r_d.pin.we_n  = 1'b0;     // write strobe with select in the same cycle, device keeps bus off
               r_d.pin.ce_n  = 1'b0;
               r_d.pin.dq    = r_q.req.wdata;
               r_d.pin.dq_oe = wide ? 16'hffff : 16'h00ff;
            end else begin
               r_d.pin.we_n = 1'b1;
               r_d.pin.ce_n = 1'b0;      // select-timed read step
               r_d.pin.oe_n = 1'b0;
            end
         end
         nvs_pkg::ST_PULSE: begin
            // hold the strobes for the whole cycle time
            r_d.cnt = r_q.cnt + 8'h01;
            if (r_q.req.op == nvs_pkg::OP_HW_SAVE) begin
               if (r_q.cnt == 8'(nvs_pkg::HW_SAVE_CYC - 1)) begin
                  r_d.pin.busy_out = 1'b1;
                  r_d.pin.busy_oe  = 1'b0;
                  r_d.cnt          = 8'h00;
                  r_d.st           = nvs_pkg::ST_GAP;
               end
            end else if (r_q.cnt == 8'(nvs_pkg::ACCESS_CYC - 1)) begin
               r_d.pin.ce_n  = 1'b1;
               r_d.pin.we_n  = 1'b1;
               r_d.pin.oe_n  = 1'b1;
               r_d.pin.dq_oe = 16'h0000;
               r_d.cnt       = 8'h00;
               r_d.st        = nvs_pkg::ST_GAP;
               if (r_q.req.op == nvs_pkg::OP_READ) begin
                  r_d.rvalid = 1'b1;
                  r_d.rdata  = wide ? r_q.dq_sync[31:16] : {8'h00, r_q.dq_sync[23:16]};
               end
               // command step read data may be junk; never handed back
            end
         end
         nvs_pkg::ST_GAP: begin
            // select high between steps lets the device count each read
            // also gives the device its grace window before a save
            // the address itself changes only at the end of setup, as select falls
            r_d.cnt = r_q.cnt + 8'h01;
            if (r_q.cnt == 8'(nvs_pkg::GRACE_CYC - 1)) begin
               if (r_q.req.op == nvs_pkg::OP_SOFT_CMD && r_q.seq != 3'(nvs_pkg::SOFT_SEQ_LEN - 1)) begin
                  r_d.seq = r_q.seq + 3'h1;
                  r_d.st  = nvs_pkg::ST_SETUP;
               end else begin
                  r_d.st = nvs_pkg::ST_BUSY;
               end
            end
         end
         nvs_pkg::ST_BUSY: begin
            // wait for the device to release the busy line
            // no timeout: a save may hold the line for milliseconds
            // and the host must not start an access before it ends
            if (r_q.bsy_sync[1]) begin
               r_d.st    = nvs_pkg::ST_IDLE;
               r_d.ready = 1'b1;
            end
         end
         default: r_d.st = nvs_pkg::ST_IDLE;
      endcase
   end

   // state register; reset parks every strobe inactive
   // reset is synchronous, so it needs a running clock
   always_ff @(posedge MCLK_I) begin
      if (RESET_I) begin
         r_q              <= '0;
         r_q.st           <= nvs_pkg::ST_IDLE;
         r_q.pin.ce_n     <= 1'b1;
         r_q.pin.we_n     <= 1'b1;
         r_q.pin.oe_n     <= 1'b1;
         r_q.pin.ub_n     <= 1'b1;
         r_q.pin.lb_n     <= 1'b1;
         r_q.pin.busy_out <= 1'b1;
      end else begin
         r_q <= r_d;
      end
   end

   // every output is a flop bit of the state struct
   // one-hot coding lets the busy flag be a single state bit,
   // so no decode sits between the register and the pin
   assign REQ_READY_O      = r_q.ready;
   assign RDATA_VALID_O    = r_q.rvalid;
   assign RDATA_O          = r_q.rdata;
   assign NV_BUSY_O        = r_q.st[4];  // bit of ST_BUSY
   assign CE_N_O           = r_q.pin.ce_n;
   assign WE_N_O           = r_q.pin.we_n;
   assign OE_N_O           = r_q.pin.oe_n;
   assign UB_N_O           = r_q.pin.ub_n;
   assign LB_N_O           = r_q.pin.lb_n;
   assign ADDR_O           = r_q.pin.addr;
   assign DQ_O             = r_q.pin.dq;
   assign DQ_OE_O          = r_q.pin.dq_oe;
   assign BUSY_LINE_N_O    = r_q.pin.busy_out;
   assign BUSY_LINE_N_OE_O = r_q.pin.busy_oe;
endmodule

// >>> tb/nvs_chk.sv
module nvs_chk (
   input wire logic                 MCLK_I,
   input wire logic                 RESET_I,
   input wire logic                 REQ_VALID_I,
   input wire nvs_pkg::nvs_req_type REQ_I,
   input wire logic                 REQ_READY_O,
   input wire logic                 RDATA_VALID_O,
   input wire logic                 NV_BUSY_O,
   input wire logic                 CE_N_O,
   input wire logic                 WE_N_O,
   input wire logic                 OE_N_O,
   input wire logic [19:0]          ADDR_O,
   input wire logic                 BUSY_LINE_N_OE_O
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (RESET_I);
   // strobes tied back to the request that caused them
   a_read_we_high: assert property (!CE_N_O && !OE_N_O |-> WE_N_O) else $error("write strobe low in read");
   a_busy_vs_access: assert property (!CE_N_O |-> !BUSY_LINE_N_OE_O) else $error("busy line pulled in access");
   a_store_pulse_len: assert property ($rose(BUSY_LINE_N_OE_O) |=> BUSY_LINE_N_OE_O)
      else $error("store pulse too short");
   a_read_answer: assert property (REQ_VALID_I && REQ_READY_O && REQ_I.op == nvs_pkg::OP_READ |-> ##7 RDATA_VALID_O)
      else $error("read data late");
   a_soft_no_data: assert property (REQ_VALID_I && REQ_READY_O && REQ_I.op == nvs_pkg::OP_SOFT_CMD
      |-> ##1 (!RDATA_VALID_O) [*8]) else $error("soft command returned data");
   a_addr_steady: assert property (!CE_N_O && !$past(CE_N_O) |-> $stable(ADDR_O)) else $error("address moved");
   a_busy_no_access: assert property (NV_BUSY_O |-> CE_N_O && !REQ_READY_O) else $error("access while busy");
   a_access_hold: assert property ($fell(CE_N_O) |-> (!CE_N_O) [*4]) else $error("select pulse short");
   // main scenarios reached
   c_read: cover property (RDATA_VALID_O);
   c_write: cover property (!CE_N_O && !WE_N_O);
   c_save: cover property ($rose(BUSY_LINE_N_OE_O));
   c_wait: cover property (NV_BUSY_O);
endmodule
bind nvs_host nvs_chk u_chk (.*);

// >>> tb/nvs_dev.sv
module nvs_dev #(
   parameter int BOOT_CYC = 30,
   parameter int SAVE_CYC = 60
) (
   input  wire logic                  clk_i,
   input  wire nvs_pkg::nvs_pins_type pins_i,
   output logic [15:0]                dq_o,
   output logic                       busy_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [32] = '{default: '0};
   logic        dirty = 0, mute = 0, ce_q = 1, pat = 0;
   int          busy = BOOT_CYC, seq = 0, cmds = 0; // power-up restore holds the bus first
   logic [15:0] ln;
   logic        rd;
   // released lanes toggle so stale data never looks valid
   assign ln = {{8{!pins_i.ub_n}}, {8{!pins_i.lb_n}}};
   assign rd = !pins_i.ce_n && pins_i.we_n && !pins_i.oe_n && !mute && busy == 0;
   assign dq_o = rd ? (mem[pins_i.addr[4:0]] & ln) | ({16{pat}} & ~ln) : {16{pat}};
   assign busy_n_o = !(pins_i.busy_oe && !pins_i.busy_out) && busy == 0; // pulled up, either side sinks
   // array, dirty flag and command sequence
   always @(posedge clk_i) begin
      pat <= !pat;
      ce_q <= pins_i.ce_n;
      if (!pins_i.ce_n && ce_q) mute <= !pins_i.we_n;
      if (busy != 0) begin
         busy <= busy - 1; // accesses ignored
      end else if (!busy_n_o) begin
         busy <= dirty ? SAVE_CYC : 0; // clean array skips the save
         dirty <= 1'b0;
      end else if (!pins_i.ce_n && !pins_i.we_n) begin
         mem[pins_i.addr[4:0]] <= (mem[pins_i.addr[4:0]] & ~ln) | (pins_i.dq & ln);
         dirty <= 1'b1;
         seq <= 0;
      end else if (!pins_i.ce_n && ce_q) begin
         seq <= pins_i.addr == 20'(seq) ? seq + 1 : 0;
         if (seq == 5 && pins_i.addr == 20'h5) begin
            busy <= 20;
            cmds <= cmds + 1;
            dirty <= 1'b0;
         end
      end
   end
endmodule

// >>> tb/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic                  mclk = 0, rst = 1, vld = 0, rdv, rdy, nvb, bsy_n;
   logic [15:0]           rdata, dq_in, ref_mem [32] = '{default: '0};
   nvs_pkg::nvs_req_type  req = '0;
   wire nvs_pkg::nvs_pins_type pins;  // a net, so each pin field may have its own driver
   int                    err_count = 0, check_count = 0, n_rd = 0, rdv_n = 0;
   initial begin
      forever #5 mclk = !mclk;
   end
   nvs_host u_dut (.MCLK_I(mclk), .RESET_I(rst), .REQ_VALID_I(vld), .REQ_I(req), .REQ_READY_O(rdy),
      .RDATA_VALID_O(rdv), .RDATA_O(rdata), .NV_BUSY_O(nvb), .CE_N_O(pins.ce_n), .WE_N_O(pins.we_n),
      .OE_N_O(pins.oe_n), .UB_N_O(pins.ub_n), .LB_N_O(pins.lb_n), .ADDR_O(pins.addr), .DQ_O(pins.dq),
      .DQ_OE_O(pins.dq_oe), .DQ_I(dq_in), .BUSY_LINE_N_O(pins.busy_out), .BUSY_LINE_N_OE_O(pins.busy_oe),
      .BUSY_LINE_N_I(bsy_n));
   nvs_dev u_dev (.clk_i(mclk), .pins_i(pins), .dq_o(dq_in), .busy_n_o(bsy_n));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // one request, held until taken; reads compared on the selected lanes only
   task automatic do_op(input logic [1:0] op, input logic [4:0] a, input logic [15:0] d, input logic [1:0] ln);
      logic [15:0] m;
      int          i;
      m = {{8{!ln[1]}}, {8{!ln[0]}}};
      i = 0;
      @(posedge mclk);
      vld <= 1'b1;
      req <= '{op: op, addr: 20'(a), wdata: d, lanes_n: ln};
      do begin
         @(posedge mclk);
         i++;
      end while (rdy !== 1'b1 && i < 2000);
      vld <= 1'b0;
      if (i >= 2000) err_count++;  // a stuck handshake counts against the run
      if (op == nvs_pkg::OP_WRITE) ref_mem[a] = (ref_mem[a] & ~m) | (d & m);
      if (op == nvs_pkg::OP_READ) begin
         n_rd++;
         i = 0;
         do begin
            @(posedge mclk);
            i++;
         end while (rdv !== 1'b1 && i < 50);
         if (i >= 50) err_count++;  // read data never arrived
         chk(rdata & m, ref_mem[a] & m);
      end
   endtask
   // a real save keeps the host waiting far longer than a skipped one
   task automatic hw_save(input logic lng);
      int n;
      int b;
      n = 0;
      b = 0;
      do_op(nvs_pkg::OP_HW_SAVE, 5'h0, 16'h0, 2'h0);
      do begin
         @(posedge mclk);
         n++;
         if (nvb === 1'b1) b++;
      end while (rdy !== 1'b1 && n < 500);
      if (n >= 500) err_count++;  // busy line never released
      chk(16'(n > 40), 16'(lng));
      chk(16'(b > 40), 16'(lng));
   endtask
   always @(posedge mclk) begin
      if (rdv === 1'b1) rdv_n++;
   end
   initial begin
      logic [1:0] op, ln;
      void'($urandom(32'h7e88));
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      repeat (4) @(posedge mclk);
      chk(16'(rdy), 16'h0);
      for (int i = 0; i < 80; i++) begin
         op = 2'($urandom % 2);
         ln = 2'($urandom % 4);
         do_op(op, 5'(8 + $urandom % 24), 16'($urandom), ln);
         if (i == 39) begin
            hw_save(1'b1);
            hw_save(1'b0);
            do_op(nvs_pkg::OP_SOFT_CMD, 5'h0, 16'h0, 2'h0);
            repeat (100) @(posedge mclk);
            chk(16'(u_dev.cmds), 16'h1);
         end
      end
      chk(16'(rdv_n), 16'(n_rd));
      end_sim();
   end
   // hang guard
   initial begin
      #100us;
      err_count++;
      end_sim();
   end
endmodule
